// >>> hdl/mmp_pkg.sv
// Shared constants and types of the PHY-end model of the media-independent port
// Functional notes
// RL1: Device makes the 1.5 MHz management clock
// RL2: Management data bits timed by management clock rise
// RL3: Management frames follow standard read/write framing
// RL4: Receive clock comes from this PHY end
// RL5: Receive nibble driven in receive clock domain
// RL6: Receive valid high exactly while nibble carries data
// RL7: Receive error raised to flag a bad nibble
// RL8: Collision output high whenever a collision exists
// RL9: Carrier sense high while either medium busy
// RL10: Transmit clock comes from this PHY end
// RL11: Device changes transmit nibble on clock rise
// RL12: Device holds transmit enable during frame data
// RL13: Device raises transmit error to inject coding error
// RL14: Transmit error nibbles reported as invalid code-groups
// RL15: Pins serve the port only when selected; port2_function_select gates only the device model's receive capture
// RL16: Device synchronises carrier and collision inputs
package mmp_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int SYS_CLK_KHZ = 10000;
  localparam int MII_CLK_KHZ = 2500;
  localparam int MII_DIV = SYS_CLK_KHZ / MII_CLK_KHZ;
  localparam int MDC_CLK_KHZ = 1500;

  // ----------------------------------------------------------------
  // Management frame layout
  // ----------------------------------------------------------------
  localparam int PREAMBLE_BITS = 32;
  localparam int HDR_BITS = 12;
  localparam int DATA_BITS = 16;
  localparam int OP_MSB = 11;
  localparam int OP_LSB = 10;
  localparam int PHY_MSB = 9;
  localparam int PHY_LSB = 5;
  localparam int REG_MSB = 4;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // ----------------------------------------------------------------
  // Management register map
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ID1 = 5'h02;
  localparam logic [4:0] REG_ID2 = 5'h03;
  localparam int CTRL_LOOP_BIT = 14;
  localparam int STAT_LINK_BIT = 2;
  localparam logic [15:0] STAT_FIXED = 16'h0000;

  typedef enum logic [2:0] {
    MMP_IDLE = 3'b000,
    MMP_START = 3'b001,
    MMP_HDR = 3'b010,
    MMP_TA = 3'b011,
    MMP_DATA = 3'b100
  } mmp_mgmt_state_e;

endpackage : mmp_pkg

// >>> hdl/mmp_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module mmp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : mmp_sync

// >>> hdl/mmp_regmem.sv
// Small register memory with registered read port
`timescale 1ns/1ps
module mmp_regmem #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_r
);

  logic [DW-1:0] mem_r [2**AW];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_r[i] <= '0;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem_r[raddr];
    end
  end

endmodule : mmp_regmem

// >>> hdl/mmp_phy_end.sv
// PHY-end controller: makes MII clocks, drives receive side, serves management
`timescale 1ns/1ps
module mmp_phy_end #(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter logic [15:0] ID1_VAL = 16'h1A2B, // Arbitrary value
  parameter logic [15:0] ID2_VAL = 16'h3C4D, // Arbitrary value
  parameter int DIV = mmp_pkg::MII_DIV
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic tx_clk,
  output logic rx_clk,
  input wire logic [3:0] transmit_nibble,
  input wire logic tx_en,
  input wire logic tx_er,
  output logic [3:0] receive_nibble,
  output logic rx_dv,
  output logic rx_er,
  output logic col,
  output logic crs,
  input wire logic [3:0] rx_src_nibble,
  input wire logic rx_src_valid,
  input wire logic rx_src_err,
  output logic rx_src_ready,
  input wire logic carrier_force,
  input wire logic col_force,
  output logic [3:0] tx_snk_nibble,
  output logic tx_snk_valid,
  output logic tx_snk_err,
  output logic tx_snk_end,
  input wire logic link_up,
  output logic loopback
);

  localparam int PW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [PW-1:0] HALF = PW'(DIV / 2);
  localparam logic [PW-1:0] LAST_PH = PW'(DIV - 1);
  localparam logic [PW-1:0] FALL_PH = PW'(DIV / 2 - 1);

  initial begin
    if (DIV < 4 || (DIV % 2) != 0) begin
      $error("DIV must be even and at least 4");
    end
  end

  // ----------------------------------------------------------------
  // MII clock divider
  // ----------------------------------------------------------------
  logic [PW-1:0] phase_r;
  logic [PW-1:0] phase_nxt;
  logic mii_clk_r;
  logic fall_evt;
  logic sample_evt;

  assign phase_nxt = (phase_r == LAST_PH) ? '0 : phase_r + PW'(1);
  assign fall_evt = (phase_r == FALL_PH);
  assign sample_evt = (phase_r == LAST_PH);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      // Last phase at reset, so the first high half is full length
      phase_r <= LAST_PH;
      mii_clk_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      mii_clk_r <= (phase_nxt < HALF); // RL4 RL10
    end
  end

  assign tx_clk = mii_clk_r;
  assign rx_clk = mii_clk_r;

  // ----------------------------------------------------------------
  // Transmit capture
  // ----------------------------------------------------------------
  logic [5:0] tx_pins_s;
  logic tx_en_s;
  logic tx_er_s;
  logic tx_prev_en_r;
  logic loop_s;

  mmp_sync #(.W(6)) u_tx_sync (
    .clk(clk_sys),
    .rst(srst),
    .d({tx_er, tx_en, transmit_nibble}),
    .q(tx_pins_s)
  );

  assign tx_en_s = tx_pins_s[4];
  assign tx_er_s = tx_pins_s[5];

  // Sampled at the last low phase, well clear of the rising edge launch
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_snk_nibble <= '0;
      tx_snk_valid <= 1'b0;
      tx_snk_err <= 1'b0;
      tx_snk_end <= 1'b0;
      tx_prev_en_r <= 1'b0;
    end else if (sample_evt) begin
      tx_snk_nibble <= tx_pins_s[3:0]; // RL11
      tx_snk_valid <= tx_en_s; // RL12
      tx_snk_err <= tx_en_s && tx_er_s; // RL13 RL14
      tx_snk_end <= tx_prev_en_r && !tx_en_s;
      tx_prev_en_r <= tx_en_s;
    end else begin
      tx_snk_valid <= 1'b0;
      tx_snk_end <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Receive drive
  // ----------------------------------------------------------------
  assign rx_src_ready = fall_evt && !loop_s;

  // Changes with the falling clock so the device sees stable data at the rise
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      receive_nibble <= '0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
    end else if (fall_evt) begin
      if (loop_s) begin
        receive_nibble <= tx_pins_s[3:0];
        rx_dv <= tx_en_s;
        rx_er <= tx_en_s && tx_er_s;
      end else begin
        receive_nibble <= rx_src_valid ? rx_src_nibble : 4'h0; // RL5
        rx_dv <= rx_src_valid; // RL6
        rx_er <= rx_src_valid && rx_src_err; // RL7
      end
    end
  end

  // ----------------------------------------------------------------
  // Collision and carrier
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      col <= 1'b0;
      crs <= 1'b0;
    end else begin
      col <= col_force || (tx_en_s && rx_dv && !loop_s); // RL8
      crs <= carrier_force || rx_dv || tx_en_s; // RL9
    end
  end

  // ----------------------------------------------------------------
  // Management slave on the device-made clock
  // ----------------------------------------------------------------
  logic mdc_rst;
  logic link_m;
  mmp_pkg::mmp_mgmt_state_e state_r;
  logic [5:0] cnt_r;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [1:0] op_r;
  logic [4:0] reg_r;
  logic hit_r;
  logic rd_hit;
  logic ctrl_loop_r;
  logic mem_we;
  logic [15:0] mem_rdata;
  logic [15:0] rd_word;
  logic [1:0] hdr_op;
  logic [4:0] hdr_phy;

  // Reset only reaches this domain while the device runs its clock
  mmp_sync #(.W(1)) u_rst_sync (
    .clk(mdc),
    .rst(1'b0),
    .d(srst),
    .q(mdc_rst)
  );

  mmp_sync #(.W(1)) u_link_sync (
    .clk(mdc),
    .rst(mdc_rst),
    .d(link_up),
    .q(link_m)
  );

  mmp_sync #(.W(1)) u_loop_sync (
    .clk(clk_sys),
    .rst(srst),
    .d(ctrl_loop_r),
    .q(loop_s)
  );

  assign loopback = loop_s;
  assign shift_nxt = {shift_r[14:0], mdio_in};
  assign hdr_op = shift_nxt[mmp_pkg::OP_MSB:mmp_pkg::OP_LSB];
  assign hdr_phy = shift_nxt[mmp_pkg::PHY_MSB:mmp_pkg::PHY_LSB];
  assign rd_hit = hit_r && (op_r == mmp_pkg::OP_READ);
  assign mem_we = (state_r == mmp_pkg::MMP_DATA) && hit_r && (op_r == mmp_pkg::OP_WRITE) &&
                  (cnt_r == 6'(mmp_pkg::DATA_BITS - 1)) && (reg_r != mmp_pkg::REG_STAT);

  always_comb begin
    rd_word = mem_rdata;
    if (reg_r == mmp_pkg::REG_STAT) begin
      rd_word = mmp_pkg::STAT_FIXED;
      rd_word[mmp_pkg::STAT_LINK_BIT] = link_m;
    end else if (reg_r == mmp_pkg::REG_ID1) begin
      rd_word = ID1_VAL;
    end else if (reg_r == mmp_pkg::REG_ID2) begin
      rd_word = ID2_VAL;
    end
  end

  mmp_regmem #(.AW(5), .DW(16)) u_regs (
    .clk(mdc),
    .rst(mdc_rst),
    .we(mem_we),
    .waddr(reg_r),
    .wdata(shift_nxt),
    .raddr(reg_r),
    .rdata_r(mem_rdata)
  );

  // All sampling and driving on the rising management clock
  always_ff @(posedge mdc) begin // RL1 RL2
    if (mdc_rst) begin
      state_r <= mmp_pkg::MMP_IDLE;
      cnt_r <= '0;
      shift_r <= '0;
      op_r <= '0;
      reg_r <= '0;
      hit_r <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else begin
      case (state_r)
        mmp_pkg::MMP_IDLE: begin
          mdio_oe <= 1'b0;
          if (mdio_in) begin
            if (cnt_r < 6'(mmp_pkg::PREAMBLE_BITS)) begin
              cnt_r <= cnt_r + 6'(1);
            end
          end else begin
            if (cnt_r == 6'(mmp_pkg::PREAMBLE_BITS)) begin
              state_r <= mmp_pkg::MMP_START; // RL3
            end
            cnt_r <= '0;
          end
        end
        mmp_pkg::MMP_START: begin
          cnt_r <= '0;
          state_r <= mdio_in ? mmp_pkg::MMP_HDR : mmp_pkg::MMP_IDLE;
        end
        mmp_pkg::MMP_HDR: begin
          shift_r <= shift_nxt;
          cnt_r <= cnt_r + 6'(1);
          if (cnt_r == 6'(mmp_pkg::HDR_BITS - 1)) begin
            cnt_r <= '0;
            op_r <= hdr_op;
            reg_r <= shift_nxt[mmp_pkg::REG_MSB:0];
            hit_r <= (hdr_phy == PHY_ADDR);
            if (hdr_op == mmp_pkg::OP_READ || hdr_op == mmp_pkg::OP_WRITE) begin
              state_r <= mmp_pkg::MMP_TA; // RL3
            end else begin
              state_r <= mmp_pkg::MMP_IDLE;
            end
          end
        end
        mmp_pkg::MMP_TA: begin
          cnt_r <= cnt_r + 6'(1);
          if (cnt_r == 6'(0)) begin
            mdio_oe <= rd_hit; // RL3
            mdio_out <= 1'b0;
          end else begin
            cnt_r <= '0;
            shift_r <= rd_word;
            mdio_out <= rd_hit && rd_word[15];
            state_r <= mmp_pkg::MMP_DATA;
          end
        end
        mmp_pkg::MMP_DATA: begin
          cnt_r <= cnt_r + 6'(1);
          if (rd_hit) begin
            shift_r <= {shift_r[14:0], 1'b0};
            mdio_out <= shift_r[14];
          end else begin
            shift_r <= shift_nxt;
          end
          if (cnt_r == 6'(mmp_pkg::DATA_BITS - 1)) begin
            cnt_r <= '0;
            mdio_oe <= 1'b0;
            mdio_out <= 1'b0;
            state_r <= mmp_pkg::MMP_IDLE;
          end
        end
        default: begin
          state_r <= mmp_pkg::MMP_IDLE;
        end
      endcase
    end
  end

  // Loopback mirror kept as a flop, since the memory output only shows the register the last frame addressed
  always_ff @(posedge mdc) begin
    if (mdc_rst) begin
      ctrl_loop_r <= 1'b0;
    end else if (mem_we && reg_r == mmp_pkg::REG_CTRL) begin
      ctrl_loop_r <= shift_nxt[mmp_pkg::CTRL_LOOP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_clk_high;
    mii_clk_r [*2];
  endsequence

  sequence s_clk_low;
    !mii_clk_r [*2];
  endsequence

  property p_mii_clk_shape;
    @(posedge clk_sys) disable iff (srst)
      $rose(mii_clk_r) |-> s_clk_high ##1 s_clk_low ##1 mii_clk_r;
  endproperty
  a_mii_clk_shape: assert property (p_mii_clk_shape) else $error("MII clock shape wrong"); // RL4

  property p_rx_change_phase;
    @(posedge clk_sys) disable iff (srst)
      $changed(receive_nibble) |-> ($past(phase_r) == FALL_PH) && !mii_clk_r;
  endproperty
  a_rx_change_phase: assert property (p_rx_change_phase) else $error("Nibble moved off phase"); // RL5

  property p_rx_dv_follows;
    @(posedge clk_sys) disable iff (srst)
      (rx_src_ready && rx_src_valid) |=> rx_dv && (receive_nibble == $past(rx_src_nibble));
  endproperty
  a_rx_dv_follows: assert property (p_rx_dv_follows) else $error("Valid nibble not driven"); // RL6

  property p_rx_er_follows;
    @(posedge clk_sys) disable iff (srst)
      (rx_src_ready && rx_src_valid && rx_src_err) |=> rx_er [*4];
  endproperty
  a_rx_er_follows: assert property (p_rx_er_follows) else $error("Receive error too short"); // RL7

  property p_col_force;
    @(posedge clk_sys) disable iff (srst)
      col_force |=> col;
  endproperty
  a_col_force: assert property (p_col_force) else $error("Collision not shown"); // RL8

  property p_crs_busy;
    @(posedge clk_sys) disable iff (srst)
      (rx_dv || carrier_force) |=> crs;
  endproperty
  a_crs_busy: assert property (p_crs_busy) else $error("Carrier sense missing"); // RL9

  property p_tx_sample_phase;
    @(posedge clk_sys) disable iff (srst)
      tx_snk_valid |-> ($past(phase_r) == LAST_PH) && !(tx_snk_err && !$past(tx_er_s));
  endproperty
  a_tx_sample_phase: assert property (p_tx_sample_phase) else $error("Capture off phase"); // RL14

  property p_ta_drive_zero;
    @(posedge mdc) disable iff (mdc_rst)
      (state_r == mmp_pkg::MMP_TA && cnt_r == 6'(0) && rd_hit) |=> mdio_oe && !mdio_out;
  endproperty
  a_ta_drive_zero: assert property (p_ta_drive_zero) else $error("Turnaround not driven low"); // RL3

  property p_read_length;
    @(posedge mdc) disable iff (mdc_rst)
      $rose(mdio_oe) |-> mdio_oe [*8] ##10 !mdio_oe;
  endproperty
  a_read_length: assert property (p_read_length) else $error("Read drive length wrong"); // RL2

  property p_oe_only_read;
    @(posedge mdc) disable iff (mdc_rst)
      mdio_oe |-> rd_hit && (state_r == mmp_pkg::MMP_TA || state_r == mmp_pkg::MMP_DATA);
  endproperty
  a_oe_only_read: assert property (p_oe_only_read) else $error("Drive outside read"); // RL3

endmodule : mmp_phy_end

// >>> dv/mmp_mac_model.sv
// Device-side model: management master, transmit nibble source, receive sink
`timescale 1ns/1ps
module mmp_mac_model (
  input wire logic clk_sys,
  input wire logic srst,
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic tx_clk,
  input wire logic rx_clk,
  output logic [3:0] transmit_nibble,
  output logic tx_en,
  output logic tx_er,
  input wire logic [3:0] receive_nibble,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic crs,
  input wire logic col
);
  logic [3:0] acc_r = 4'h0;
  logic run = 1'b0;
  logic m_oe = 1'b0;
  logic m_out = 1'b1;
  logic [4:0] rxq [$];
  logic port2_function_select = 1'b1;
  logic [1:0] crs_q = 2'h0;
  logic [1:0] col_q = 2'h0;
  initial begin
    mdc = 1'b0;
    transmit_nibble = 4'h0;
    tx_en = 1'b0;
    tx_er = 1'b0;
  end
  // ----------------------------------------------------------------
  // Management clock
  // ----------------------------------------------------------------
  // Fractional divide by 20/3: exact mean rate, one-cycle jitter on edges
  always @(posedge clk_sys) begin
    if (srst || run) begin
      if (acc_r >= 4'h7) begin
        acc_r <= acc_r - 4'h7;
        mdc <= ~mdc;
      end else begin
        acc_r <= acc_r + 4'h3;
      end
    end
  end
  // Pull-up wins when neither side drives
  assign mdio_in = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);
  // ----------------------------------------------------------------
  // Management frame, 18 samples returned from turnaround onward
  // ----------------------------------------------------------------
  task automatic mgmt(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                      input logic [15:0] wd, output logic [17:0] rd);
    logic [63:0] fr;
    fr = {32'hFFFFFFFF, 2'h1, op, phy, rg, 2'h2, wd};
    rd = 18'h00000;
    run = 1'b1;
    // Idle ones first: the far end needs a few edges to leave reset
    repeat (3) @(posedge mdc);
    for (int i = 63; i >= 0; i--) begin
      @(negedge mdc);
      m_oe = (op == mmp_pkg::OP_WRITE) || (i > 17);
      m_out = fr[i];
      @(posedge mdc);
      if (i <= 17) rd = {rd[16:0], mdio_in};
    end
    @(negedge mdc);
    m_oe = 1'b0;
    run = 1'b0;
  endtask : mgmt
  // ----------------------------------------------------------------
  // Nibble paths
  // ----------------------------------------------------------------
  task automatic tx_send(input logic [15:0] nib, input logic [3:0] err);
    for (int i = 0; i < 4; i++) begin
      @(posedge tx_clk);
      tx_en <= 1'b1;
      transmit_nibble <= nib[4*i +: 4];
      tx_er <= err[i];
    end
    @(posedge tx_clk);
    tx_en <= 1'b0;
    tx_er <= 1'b0;
    transmit_nibble <= ~nib[15:12];
  endtask : tx_send
  always @(posedge rx_clk) begin
    if (port2_function_select && rx_dv === 1'b1) rxq.push_back({rx_er, receive_nibble});
  end
  // Carrier and collision arrive unclocked, so two stages before use
  always @(posedge clk_sys) begin
    crs_q <= {crs_q[0], crs};
    col_q <= {col_q[0], col};
  end
endmodule : mmp_mac_model

// >>> dv/mmp_phy_end_bench.sv
// Self-checking bench of the PHY-end controller
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module mmp_phy_end_bench;
  localparam logic [15:0] ID1 = 16'h5A3C; // Arbitrary value
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic mdc;
  logic mdio_in;
  logic mdio_out;
  logic mdio_oe;
  logic tx_clk;
  logic rx_clk;
  logic [3:0] transmit_nibble;
  logic tx_en;
  logic tx_er;
  logic [3:0] receive_nibble;
  logic rx_dv;
  logic rx_er;
  logic col;
  logic crs;
  logic [3:0] rx_src_nibble = 4'h0;
  logic rx_src_valid = 1'b0;
  logic rx_src_err = 1'b0;
  logic rx_src_ready;
  logic carrier_force = 1'b0;
  logic col_force = 1'b0;
  logic [3:0] tx_snk_nibble;
  logic tx_snk_valid;
  logic tx_snk_err;
  logic tx_snk_end;
  logic link_up = 1'b1;
  logic loopback;
  logic col_seen = 1'b0;
  logic [4:0] txq [$];
  int n_end = 0;
  int n_fail = 0;
  int cmp_count = 0;
  always #50 clk_sys = ~clk_sys;
  mmp_phy_end #(.PHY_ADDR(5'h01), .ID1_VAL(ID1)) uut (.clk_sys(clk_sys), .srst(srst),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .tx_clk(tx_clk),
    .rx_clk(rx_clk), .transmit_nibble(transmit_nibble), .tx_en(tx_en), .tx_er(tx_er),
    .receive_nibble(receive_nibble), .rx_dv(rx_dv), .rx_er(rx_er), .col(col), .crs(crs),
    .rx_src_nibble(rx_src_nibble), .rx_src_valid(rx_src_valid), .rx_src_err(rx_src_err),
    .rx_src_ready(rx_src_ready), .carrier_force(carrier_force), .col_force(col_force),
    .tx_snk_nibble(tx_snk_nibble), .tx_snk_valid(tx_snk_valid), .tx_snk_err(tx_snk_err),
    .tx_snk_end(tx_snk_end), .link_up(link_up), .loopback(loopback));
  mmp_mac_model m (.clk_sys(clk_sys), .srst(srst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .tx_clk(tx_clk), .rx_clk(rx_clk),
    .transmit_nibble(transmit_nibble), .tx_en(tx_en), .tx_er(tx_er),
    .receive_nibble(receive_nibble), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .col(col));
  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (tx_snk_valid === 1'b1) txq.push_back({tx_snk_err, tx_snk_nibble});
    if (tx_snk_end === 1'b1) n_end++;
    if (m.col_q[1] === 1'b1) col_seen = 1'b1;
  end
  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Bounded wait; ends on the edge that takes the nibble
  task automatic wait_ready();
    int k;
    for (k = 0; k < 8; k++) begin
      @(negedge clk_sys);
      if (rx_src_ready === 1'b1) break;
    end
    if (k == 8) n_fail++;
    @(posedge clk_sys);
  endtask : wait_ready
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_receive();
    logic [15:0] nib;
    nib = 16'hC3A5;
    m.rxq.delete();
    @(posedge clk_sys);
    for (int i = 0; i <= 4; i++) begin
      rx_src_valid <= (i < 4);
      rx_src_nibble <= nib[4*(i%4) +: 4];
      rx_src_err <= (i == 2);
      wait_ready();
      if (i == 3) `CHK(crs, 1'b1);
    end
    repeat (8) @(posedge clk_sys);
    `CHK(m.rxq.size(), 4);
    for (int i = 0; i < 4 && i < m.rxq.size(); i++) begin
      `CHK(m.rxq[i], {(i == 2), nib[4*i +: 4]});
    end
  endtask : t_receive
  task automatic t_transmit();
    txq.delete();
    n_end = 0;
    m.tx_send(16'h96E1, 4'h4);
    repeat (12) @(posedge clk_sys);
    `CHK(txq.size(), 4);
    for (int i = 0; i < 4 && i < txq.size(); i++) begin
      `CHK(txq[i], {(i == 2), 4'(16'h96E1 >> (4 * i))});
    end
    `CHK(n_end, 1);
    `CHK(crs, 1'b0);
  endtask : t_transmit
  // Both media busy at once must show as a collision
  task automatic t_collision();
    col_seen = 1'b0;
    fork
      m.tx_send(16'h1234, 4'h0);
      t_receive();
    join
    `CHK(col_seen, 1'b1);
  endtask : t_collision
  task automatic t_force();
    for (int v = 0; v < 4; v++) begin
      @(posedge clk_sys);
      carrier_force <= v[0];
      col_force <= v[1];
      repeat (3) @(posedge clk_sys);
      `CHK(crs, v[0]);
      `CHK(col, v[1]);
    end
    carrier_force <= 1'b0;
    col_force <= 1'b0;
  endtask : t_force
  // Pins given to another function must not feed the receive path
  task automatic t_unselected();
    m.port2_function_select = 1'b0;
    m.rxq.delete();
    @(posedge clk_sys);
    rx_src_valid <= 1'b1;
    rx_src_nibble <= 4'h7;
    wait_ready();
    rx_src_valid <= 1'b0;
    repeat (8) @(posedge clk_sys);
    `CHK(m.rxq.size(), 0);
    m.port2_function_select = 1'b1;
  endtask : t_unselected
  task automatic t_mgmt();
    logic [17:0] rd;
    int hits;
    m.mgmt(mmp_pkg::OP_READ, 5'h01, mmp_pkg::REG_ID1, 16'h0000, rd);
    `CHK(rd, {2'h2, ID1});
    m.mgmt(mmp_pkg::OP_WRITE, 5'h01, 5'h05, 16'hBEEF, rd);
    m.mgmt(mmp_pkg::OP_READ, 5'h01, 5'h05, 16'h0000, rd);
    `CHK(rd, {2'h2, 16'hBEEF});
    m.mgmt(mmp_pkg::OP_WRITE, 5'h01, mmp_pkg::REG_STAT, 16'hFFFF, rd);
    m.mgmt(mmp_pkg::OP_READ, 5'h01, mmp_pkg::REG_STAT, 16'h0000, rd);
    `CHK(rd, {2'h2, 16'h0004});
    m.mgmt(mmp_pkg::OP_READ, 5'h02, 5'h05, 16'h0000, rd);
    `CHK(rd, 18'h3FFFF);
    m.mgmt(mmp_pkg::OP_WRITE, 5'h01, mmp_pkg::REG_CTRL, 16'h4000, rd);
    repeat (8) @(posedge clk_sys);
    `CHK(loopback, 1'b1);
    hits = 0;
    repeat (8) begin
      @(negedge clk_sys);
      if (rx_src_ready !== 1'b0) hits++;
    end
    `CHK(hits, 0);
    // Loopback returns each sent nibble once on the receive pins
    m.rxq.delete();
    m.tx_send(16'h5A69, 4'h1);
    repeat (12) @(posedge clk_sys);
    `CHK(m.rxq.size(), 4);
    for (int i = 0; i < 4 && i < m.rxq.size(); i++) begin
      `CHK(m.rxq[i], {(i == 0), 4'(16'h5A69 >> (4 * i))});
    end
    m.mgmt(mmp_pkg::OP_WRITE, 5'h01, mmp_pkg::REG_CTRL, 16'h0000, rd);
    repeat (8) @(posedge clk_sys);
    `CHK(loopback, 1'b0);
  endtask : t_mgmt
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    // Longer than two cycles so the management side sees several edges
    repeat (30) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_receive();
    t_transmit();
    t_collision();
    t_force();
    t_unselected();
    t_mgmt();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule : mmp_phy_end_bench
